// ### shared/abs_enc_pkg.sv
package abs_enc_pkg;
    // Encoder usage codes
    localparam logic [1:0] USAGE_DEFAULT = 2'h0;
    localparam logic [1:0] USAGE_INCR = 2'h1;
    localparam logic [1:0] USAGE_SINGLE = 2'h2;
    // Widths and limits
    localparam int TURN_W = 16;
    localparam int PULSE_W = 24;
    localparam int POS_W = 40;
    localparam logic [15:0] LIMIT_DEFAULT = 16'hffff;
    localparam logic [15:0] TURN_ZERO = 16'h0000;
    localparam logic [23:0] PULSE_ZERO = 24'h000000;
    localparam logic [23:0] RES_DEFAULT = 24'h100000;

    // Encoder operating mode after restart
    typedef enum logic [1:0] {MODE_INCR, MODE_SINGLE, MODE_MULTI} enc_mode_t;

    // Encoder feedback sample
    typedef struct packed {
        logic [23:0] pulse;
        logic [15:0] turns;
        logic [15:0] enc_limit;
        logic multiturn_cap;
        logic abs_alarm_a;
        logic abs_alarm_b;
    } enc_fb_t;

    // Position report to the network side
    typedef struct packed {
        logic [39:0] position;
        logic [15:0] turns;
        logic [23:0] pulse;
        logic valid;
    } pos_report_t;
endpackage : abs_enc_pkg

// ### hw/absolute_encoder_multiturn_tracking.sv
`timescale 1ns/10ps
module absolute_encoder_multiturn_tracking (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [1:0] encoder_usage_select,
    input wire logic [15:0] multiturn_wrap_limit,
    input wire logic [23:0] pulses_per_rev,
    input wire abs_enc_pkg::enc_fb_t enc_fb,
    input wire logic enc_fb_strobe,
    output abs_enc_pkg::pos_report_t pos_report,
    output logic multiturn_limit_mismatch_alarm,
    output logic abs_enc_alarm_a,
    output logic abs_enc_alarm_b,
    output abs_enc_pkg::enc_mode_t enc_mode
);
    abs_enc_pkg::enc_mode_t mode_ff;
    logic cfg_done_ff;
    logic [15:0] limit_ff;
    logic [23:0] res_ff;
    logic [23:0] pulse_ff;
    logic [15:0] turns_ff;
    logic [15:0] enc_limit_ff;
    logic valid_ff;
    logic alarm_ff;
    logic alm_a_ff;
    logic alm_b_ff;
    logic [39:0] pos_ff;
    logic fwd_wrap;
    logic rev_wrap;
    logic [15:0] nxt_turns;
    logic is_abs;

    // Position composition
    function automatic logic [39:0] compose_pos(input logic [15:0] t, input logic [23:0] r,
                                                input logic [23:0] p);
        compose_pos = 40'(t) * 40'(r) + 40'(p);
    endfunction : compose_pos

    // Usage setting and encoder capability to operating mode
    function automatic abs_enc_pkg::enc_mode_t decode_mode(input logic [1:0] usage,
                                                          input logic cap);
        case (usage)
            abs_enc_pkg::USAGE_INCR: decode_mode = abs_enc_pkg::MODE_INCR;
            abs_enc_pkg::USAGE_SINGLE: decode_mode = abs_enc_pkg::MODE_SINGLE;
            default: decode_mode = cap ? abs_enc_pkg::MODE_MULTI
                                       : abs_enc_pkg::MODE_INCR;
        endcase
    endfunction : decode_mode

    // Mode and limit captured once after restart
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            cfg_done_ff <= 1'b0;
            mode_ff <= abs_enc_pkg::MODE_INCR;
            limit_ff <= abs_enc_pkg::LIMIT_DEFAULT;
            res_ff <= abs_enc_pkg::RES_DEFAULT;
        end
        else if (!cfg_done_ff && enc_fb_strobe)
        begin
            cfg_done_ff <= 1'b1;
            limit_ff <= multiturn_wrap_limit;
            res_ff <= pulses_per_rev;
            mode_ff <= decode_mode(encoder_usage_select, enc_fb.multiturn_cap);
        end
    end

    assign is_abs = (mode_ff != abs_enc_pkg::MODE_INCR);

    // Pulse wrap detection, forward when jumping from top to zero
    always_comb
    begin
        fwd_wrap = (pulse_ff == res_ff - 24'h000001) && (enc_fb.pulse == abs_enc_pkg::PULSE_ZERO);
        rev_wrap = (pulse_ff == abs_enc_pkg::PULSE_ZERO) && (enc_fb.pulse == res_ff - 24'h000001);
    end

    // Next turn count with limit wrap
    always_comb
    begin
        nxt_turns = turns_ff;
        if (mode_ff == abs_enc_pkg::MODE_SINGLE)
            nxt_turns = abs_enc_pkg::TURN_ZERO;
        else if (fwd_wrap)
        begin
            if (is_abs && turns_ff == limit_ff)
                nxt_turns = abs_enc_pkg::TURN_ZERO;
            else
                nxt_turns = turns_ff + 16'h0001;
        end
        else if (rev_wrap)
        begin
            if (is_abs && turns_ff == abs_enc_pkg::TURN_ZERO)
                nxt_turns = limit_ff;
            else
                nxt_turns = turns_ff - 16'h0001;
        end
    end

    // Position tracking
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            pulse_ff <= abs_enc_pkg::PULSE_ZERO;
            turns_ff <= abs_enc_pkg::TURN_ZERO;
            valid_ff <= 1'b0;
        end
        else if (enc_fb_strobe)
        begin
            pulse_ff <= enc_fb.pulse;
            valid_ff <= cfg_done_ff | valid_ff;
            // First sample loads absolute turns in multiturn mode, zero in the other modes, no homing needed
            if (!cfg_done_ff)
                turns_ff <= (decode_mode(encoder_usage_select, enc_fb.multiturn_cap) ==
                             abs_enc_pkg::MODE_MULTI) ? enc_fb.turns
                                                      : abs_enc_pkg::TURN_ZERO;
            else
                turns_ff <= nxt_turns;
        end
        else if (mode_ff == abs_enc_pkg::MODE_SINGLE)
            turns_ff <= abs_enc_pkg::TURN_ZERO;
    end

    // Position word for the network
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            pos_ff <= 40'h0;
        else
            pos_ff <= compose_pos(turns_ff, res_ff, pulse_ff);
    end

    // Encoder-held limit and alarms
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            enc_limit_ff <= abs_enc_pkg::LIMIT_DEFAULT;
            alarm_ff <= 1'b0;
            alm_a_ff <= 1'b0;
            alm_b_ff <= 1'b0;
        end
        else
        begin
            if (enc_fb_strobe)
                enc_limit_ff <= enc_fb.enc_limit;
            alarm_ff <= cfg_done_ff && mode_ff == abs_enc_pkg::MODE_MULTI &&
                        limit_ff != enc_limit_ff;
            // Encoder alarms pass only in multiturn mode, taken with each sample
            if (mode_ff != abs_enc_pkg::MODE_MULTI)
            begin
                alm_a_ff <= 1'b0;
                alm_b_ff <= 1'b0;
            end
            else if (enc_fb_strobe)
            begin
                alm_a_ff <= enc_fb.abs_alarm_a;
                alm_b_ff <= enc_fb.abs_alarm_b;
            end
        end
    end

    assign pos_report = '{position: pos_ff, turns: turns_ff, pulse: pulse_ff, valid: valid_ff};
    assign multiturn_limit_mismatch_alarm = alarm_ff;
    assign abs_enc_alarm_a = alm_a_ff;
    assign abs_enc_alarm_b = alm_b_ff;
    assign enc_mode = mode_ff;

    // Checks
    single_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        mode_ff == abs_enc_pkg::MODE_SINGLE |=> turns_ff == abs_enc_pkg::TURN_ZERO)
        else $error("turn count not zero in single-turn mode");
    rev_load_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        cfg_done_ff && enc_fb_strobe && rev_wrap && mode_ff == abs_enc_pkg::MODE_MULTI &&
        turns_ff == abs_enc_pkg::TURN_ZERO |=> turns_ff == limit_ff)
        else $error("reverse wrap did not load limit");
    fwd_wrap_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        cfg_done_ff && enc_fb_strobe && fwd_wrap && mode_ff == abs_enc_pkg::MODE_MULTI &&
        turns_ff == limit_ff |=> turns_ff == abs_enc_pkg::TURN_ZERO)
        else $error("forward wrap did not clear count");
    pos_compose_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        1'b1 |=> pos_ff == 40'($past(turns_ff)) * 40'($past(res_ff)) + 40'($past(pulse_ff)))
        else $error("position word wrong");
    mismatch_alarm_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        cfg_done_ff && mode_ff == abs_enc_pkg::MODE_MULTI && limit_ff != enc_limit_ff
        |=> alarm_ff)
        else $error("mismatch alarm missing");
    alarm_suppress_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        mode_ff == abs_enc_pkg::MODE_SINGLE |=> !alm_a_ff && !alm_b_ff)
        else $error("absolute alarm in single-turn mode");
    incr_mode_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !cfg_done_ff && enc_fb_strobe && encoder_usage_select == abs_enc_pkg::USAGE_INCR
        |=> mode_ff == abs_enc_pkg::MODE_INCR)
        else $error("usage 1 not incremental");
    mode_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        cfg_done_ff |=> $stable(mode_ff))
        else $error("mode changed without restart");
    fwd_step_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        cfg_done_ff && enc_fb_strobe && fwd_wrap && mode_ff == abs_enc_pkg::MODE_INCR
        |=> turns_ff == $past(turns_ff) + 16'h0001)
        else $error("forward step missed");
    valid_up_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        cfg_done_ff && enc_fb_strobe |=> pos_report.valid)
        else $error("position not valid after first sample");
    single_mode_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !cfg_done_ff && enc_fb_strobe && encoder_usage_select == abs_enc_pkg::USAGE_SINGLE
        |=> mode_ff == abs_enc_pkg::MODE_SINGLE)
        else $error("usage 2 not single-turn");
    multi_mode_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !cfg_done_ff && enc_fb_strobe && encoder_usage_select == abs_enc_pkg::USAGE_DEFAULT &&
        enc_fb.multiturn_cap |=> mode_ff == abs_enc_pkg::MODE_MULTI)
        else $error("usage 0 not multiturn on capable encoder");
    abs_load_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !cfg_done_ff && enc_fb_strobe && encoder_usage_select == abs_enc_pkg::USAGE_DEFAULT &&
        enc_fb.multiturn_cap |=> turns_ff == $past(enc_fb.turns))
        else $error("absolute turns not loaded at power-up");
    cov_fwd_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
        enc_fb_strobe && fwd_wrap && turns_ff == limit_ff);
    cov_rev_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
        enc_fb_strobe && rev_wrap && turns_ff == abs_enc_pkg::TURN_ZERO);
    cov_alarm_c: cover property (@(posedge ref_clk) disable iff (!rst_b) $rose(alarm_ff));
    cov_single_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
        enc_fb_strobe && fwd_wrap && mode_ff == abs_enc_pkg::MODE_SINGLE);
endmodule : absolute_encoder_multiturn_tracking

// ### tb/enc_model.sv
`timescale 1ns/10ps
// Encoder and host stand-in: pulse counter, stored limit, host memory write
module enc_model (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic step_fwd,
    input wire logic step_rev,
    input wire logic cap,
    input wire logic alarm_in,
    input wire logic [15:0] init_turns,
    input wire logic [15:0] init_limit,
    input wire logic [23:0] res,
    input wire logic wr_en,
    input wire logic [15:0] wr_val,
    output abs_enc_pkg::enc_fb_t enc_fb,
    output logic enc_fb_strobe
);
    logic [23:0] pulse_ff;
    logic [15:0] limit_ff;
    abs_enc_pkg::enc_fb_t fb;
    // Pulse count within one rotation, wraps at the resolution
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            pulse_ff <= 24'h000000;
        else if (step_fwd)
            pulse_ff <= (pulse_ff == res - 24'h000001) ? 24'h000000 : pulse_ff + 24'h000001;
        else if (step_rev)
            pulse_ff <= (pulse_ff == 24'h000000) ? res - 24'h000001 : pulse_ff - 24'h000001;
    end
    // Stored limit, reloaded from init_limit at reset, rewritten by the host
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            limit_ff <= init_limit;
        else if (wr_en)
            limit_ff <= wr_val;
    end
    // New sample every cycle once out of reset
    always_ff @(posedge ref_clk)
    begin
        enc_fb_strobe <= rst_b;
    end
    // Data is scrambled while no sample is offered
    assign fb = '{pulse_ff, init_turns, limit_ff, cap, alarm_in, alarm_in};
    assign enc_fb = enc_fb_strobe ? fb : ~fb;
endmodule : enc_model

// ### tb/tb_top.sv
`timescale 1ns/10ps
// Table of mode and wrap cases, then reset, host write and restart cases
module tb_top;
    typedef struct {
        logic [1:0] u;
        logic c;
        logic [15:0] l, el, it;
        logic fw;
        int n;
        logic [15:0] t;
        logic [23:0] p;
        abs_enc_pkg::enc_mode_t m;
        logic al;
    } row_t;
    localparam logic [23:0] RES = 24'h000004;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [1:0] usage = 2'h0;
    logic cap = 1'b1;
    logic [15:0] lim = 16'hffff, enc_lim = 16'hffff, init = 16'h0000;
    logic fwd = 1'b0, rev = 1'b0, wr_en = 1'b0;
    abs_enc_pkg::enc_fb_t enc_fb;
    logic strobe, mis_alarm, alarm_a, alarm_b;
    abs_enc_pkg::pos_report_t pos_report;
    abs_enc_pkg::enc_mode_t enc_mode;
    int fails = 0;
    int comparisons = 0;
    row_t rows[7];
    // Clock, 5 ns period
    always #2.5 ref_clk = ~ref_clk;
    absolute_encoder_multiturn_tracking absolute_encoder_multiturn_tracking_inst (
        .ref_clk(ref_clk), .rst_b(rst_b), .encoder_usage_select(usage),
        .multiturn_wrap_limit(lim), .pulses_per_rev(RES), .enc_fb(enc_fb),
        .enc_fb_strobe(strobe), .pos_report(pos_report),
        .multiturn_limit_mismatch_alarm(mis_alarm), .abs_enc_alarm_a(alarm_a),
        .abs_enc_alarm_b(alarm_b), .enc_mode(enc_mode));
    enc_model enc_model_inst (
        .ref_clk(ref_clk), .rst_b(rst_b), .step_fwd(fwd), .step_rev(rev), .cap(cap),
        .alarm_in(1'b1), .init_turns(init), .init_limit(enc_lim), .res(RES),
        .wr_en(wr_en), .wr_val(lim), .enc_fb(enc_fb), .enc_fb_strobe(strobe));
    task automatic bad(input string msg);
        fails++;
        $display("[FAIL] %0t %s", $time, msg);
    endtask : bad
    task automatic stop_test();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : stop_test
    // Power cycle with a new setting and a new stored encoder state
    task automatic restart(input row_t r);
        @(negedge ref_clk);
        rst_b = 1'b0;
        usage = r.u;
        cap = r.c;
        lim = r.l;
        enc_lim = r.el;
        init = r.it;
        repeat (3) @(negedge ref_clk);
        rst_b = 1'b1;
        repeat (4) @(negedge ref_clk);
    endtask : restart
    // Turn the shaft n pulses, then let the outputs settle
    task automatic step(input logic f, input int n);
        fwd = f;
        rev = !f;
        repeat (n) @(negedge ref_clk);
        fwd = 1'b0;
        rev = 1'b0;
        repeat (6) @(negedge ref_clk);
    endtask : step
    task automatic check(input row_t r);
        logic [39:0] pos;
        pos = 40'(r.t) * 40'(RES) + 40'(r.p);
        comparisons += 7;
        if (pos_report.pulse !== r.p) bad("pulse");
        if (pos_report.turns !== r.t) bad("turn count");
        if (pos_report.position !== pos) bad("position");
        if (pos_report.valid !== 1'b1) bad("valid");
        if (enc_mode !== r.m) bad("mode");
        if (mis_alarm !== r.al) bad("mismatch alarm");
        if ({alarm_a, alarm_b} !== {2{r.m == abs_enc_pkg::MODE_MULTI}}) bad("enc alarms");
    endtask : check
    initial
    begin
        // Gear 3 to 1 on the table side gives limit 2; forward wrap at limit
        rows[0] = '{0, 1, 16'h0002, 16'h0002, 16'h0002, 1, 4, 0, 0, abs_enc_pkg::MODE_MULTI, 0};
        rows[1] = '{0, 1, 16'h0002, 16'h0002, 0, 0, 1, 2, 3, abs_enc_pkg::MODE_MULTI, 0};
        rows[2] = '{1, 1, 16'h0002, 16'h0002, 2, 1, 12, 3, 0, abs_enc_pkg::MODE_INCR, 0};
        rows[3] = '{2, 1, 16'h0002, 16'h0009, 5, 1, 5, 0, 1, abs_enc_pkg::MODE_SINGLE, 0};
        rows[4] = '{0, 0, 16'h0002, 16'h0002, 5, 0, 1, 16'hffff, 3, abs_enc_pkg::MODE_INCR, 0};
        rows[5] = '{0, 1, 16'hffff, 16'hffff, 16'hfffe, 1, 8, 0, 0, abs_enc_pkg::MODE_MULTI, 0};
        rows[6] = '{0, 1, 16'h0002, 16'h0003, 1, 1, 1, 1, 1, abs_enc_pkg::MODE_MULTI, 1};
        foreach (rows[i])
        begin
            restart(rows[i]);
            step(rows[i].fw, rows[i].n);
            check(rows[i]);
            $display("row %0d done", i);
        end
        // Outputs while reset is held
        @(negedge ref_clk);
        rst_b = 1'b0;
        repeat (3) @(negedge ref_clk);
        comparisons += 3;
        if (pos_report !== '0 || mis_alarm !== 1'b0) bad("reset outputs");
        if ({alarm_a, alarm_b} !== 2'h0) bad("reset enc alarms");
        if (enc_mode !== abs_enc_pkg::MODE_INCR) bad("reset mode");
        $display("reset test done");
        // Host writes the matching limit into the encoder
        restart(rows[6]);
        comparisons++;
        if (mis_alarm !== 1'b1) bad("alarm before write");
        wr_en = 1'b1;
        @(negedge ref_clk);
        wr_en = 1'b0;
        repeat (4) @(negedge ref_clk);
        comparisons++;
        if (mis_alarm !== 1'b0) bad("alarm after write");
        $display("host write test done");
        // Usage change without a restart must not take effect
        restart(rows[2]);
        usage = 2'h2;
        step(1'b1, 4);
        comparisons += 2;
        if (enc_mode !== abs_enc_pkg::MODE_INCR) bad("mode changed");
        if (pos_report.turns !== 16'h0001) bad("turns after change");
        $display("restart test done");
        stop_test();
    end
    // Watchdog, far beyond the 165 or so cycles the tests need
    initial
    begin
        #100000;
        bad("timeout");
        stop_test();
    end
endmodule : tb_top
